// ==== capc_pkg.sv ====
`default_nettype none
// ----------------------------------------------------------------------
// shared constants for the compare and pwm channel
// ----------------------------------------------------------------------
package capc_pkg;

  // widths
  localparam int CMP_W  = 16;               // compare value and timer width
  localparam int PER_W  = 8;                // period timer width
  localparam int DUTY_W = 10;               // pwm time base and duty width
  localparam int ADDR_W = 12;               // apb byte address width
  localparam int DATA_W = 32;               // apb data width
  localparam int SUB_W  = 8;                // prescaler counter width, up to 256 oscillator cycles per timer step

  // register indices, byte address is four times the index
  localparam logic [9:0] IDX_VALUE  = 10'h30C;  // compare_value_register
  localparam logic [9:0] IDX_CTL    = 10'h30E;  // channel_control_register
  localparam logic [9:0] IDX_PERIOD = 10'h320;  // period_register
  localparam logic [9:0] IDX_CFG    = 10'h321;  // timer and trigger setup
  localparam logic [9:0] IDX_STS    = 10'h322;  // flags, write one to clear
  localparam logic [9:0] IDX_PTMR   = 10'h323;  // period_timer_count
  localparam logic [9:0] IDX_CTMR   = 10'h324;  // compare_timebase_counter

  // control register fields
  localparam int CTL_EN_BIT  = 7;           // channel enable
  localparam int CTL_OUT_BIT = 5;           // output latch, read only
  localparam int CTL_FMT_BIT = 4;           // alignment_select
  localparam int CTL_MODE_HI = 3;           // mode field top bit

  // setup register fields
  localparam int CFG_RUN_BIT = 0;           // timer_run_bit
  localparam int CFG_PS_LSB  = 1;           // timer_prescale_select, two bits
  localparam int CFG_ADC_BIT = 3;           // channel is converter trigger
  localparam int CFG_IE_BIT  = 4;           // match interrupt enable

  // status register fields
  localparam int STS_MATCH_BIT = 0;         // channel_match_flag
  localparam int STS_PER_BIT   = 1;         // period_timer_flag

  // mode codes
  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_TOG_CLR   = 4'h1;
  localparam logic [3:0] MODE_TOG       = 4'h2;
  localparam logic [3:0] MODE_SET       = 4'h8;
  localparam logic [3:0] MODE_CLR       = 4'h9;
  localparam logic [3:0] MODE_PULSE     = 4'hA;
  localparam logic [3:0] MODE_PULSE_CLR = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP   = 2'h3;  // 11xx selects pwm
  localparam logic [1:0] MODE_CMP_TOP   = 2'h2;  // 10xx compare group

  // reset values
  localparam logic [7:0]  RST_CTL    = 8'h00;
  localparam logic [7:0]  RST_PERIOD = 8'hFF;
  localparam logic [15:0] RST_VALUE  = 16'h0000;

  // last oscillator cycle of one timer step, four cycles times prescale
  function automatic logic [SUB_W-1:0] ps_last(input logic [1:0] sel);
    case (sel)
      2'h0:    ps_last = 8'h03;            // 1:1
      2'h1:    ps_last = 8'h0F;            // 1:4
      2'h2:    ps_last = 8'h3F;            // 1:16
      default: ps_last = 8'hFF;            // 1:64
    endcase
  endfunction : ps_last

  // compare match sequence, one bit changes per step except ST_HOLD back to ST_WAIT
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,                       // armed, waiting for equality
    ST_HIT  = 2'b01,                       // match cycle, timer clear pending
    ST_HOLD = 2'b11                        // equality still present
  } capc_cmp_state_t;

endpackage : capc_pkg
`default_nettype wire

// ==== capc_period_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// pwm period timer with prescaler and 10-bit time base
// ----------------------------------------------------------------------
module capc_period_timer #(
  parameter int PER_W = 8
) (
  input  wire logic               clk_in,        // oscillator clock
  input  wire logic               rst_n_in,      // synchronous, active low
  input  wire logic               run_in,        // timer counts
  input  wire logic [1:0]         ps_sel_in,     // prescale select
  input  wire logic [PER_W-1:0]   period_in,     // period register value
  output logic      [PER_W-1:0]   count_out,     // period timer count
  output logic      [PER_W+1:0]   base_out,      // extended time base
  output logic                    wrap_out       // wraps at this edge
);
  import capc_pkg::*;

  logic [SUB_W-1:0] sub;                         // cycles inside one step
  logic [SUB_W-1:0] last;                        // last cycle of a step
  logic [SUB_W-1:0] sub_sh;                      // sub aligned to prescale
  logic             step;                        // timer increments now

  // refuse period widths the time base cannot serve
  if (PER_W < 2 || PER_W > 16) begin : g_bad_per_w
    $error("PER_W out of range");
  end

  assign last     = ps_last(ps_sel_in);
  assign step     = run_in && (sub >= last);
  assign wrap_out = step && (count_out == period_in);
  // low bits: oscillator phase at 1:1, prescaler bits otherwise
  assign sub_sh   = sub >> {ps_sel_in, 1'b0};
  assign base_out = {count_out, sub_sh[1:0]};

  // ----------------------------------------------------------------------
  // prescaler and timer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sub       <= '0;
      count_out <= '0;
    end else if (run_in) begin
      sub <= step ? '0 : sub + 1'b1;
      if (wrap_out) begin
        count_out <= '0;
      end else if (step) begin
        count_out <= count_out + 1'b1;
      end
    end
  end

endmodule : capc_period_timer
`default_nettype wire

// ==== capc_top.sv ====
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module capc_top #(
  parameter int CMP_W = capc_pkg::CMP_W,
  parameter int PER_W = capc_pkg::PER_W
) (
  input  wire logic                        CLK_IN,                 // oscillator clock
  input  wire logic                        RST_N_IN,               // synchronous reset
  input  wire logic                        PSEL_IN,                // apb select
  input  wire logic                        PENABLE_IN,             // apb access phase
  input  wire logic                        PWRITE_IN,              // apb direction
  input  wire logic [capc_pkg::ADDR_W-1:0] PADDR_IN,               // apb byte address
  input  wire logic [capc_pkg::DATA_W-1:0] PWDATA_IN,              // apb write data
  output logic      [capc_pkg::DATA_W-1:0] PRDATA_OUT,             // apb read data
  output logic                             PREADY_OUT,             // apb ready
  output logic                             PSLVERR_OUT,            // unmapped address
  input  wire logic                        COMPARE_TICK_IN,        // compare timer clock
  input  wire logic                        SLEEP_IN,               // device in sleep
  output logic                             CHANNEL_OUTPUT_PIN_OUT, // channel pin
  output logic                             CHANNEL_SIGNAL_OUT,     // to other peripherals
  output logic                             ADC_TRIGGER_OUT,        // conversion start
  output logic                             WAKE_OUT                // wake request
);
  import capc_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [CMP_W-1:0]    value;        // compare_value_register
  logic [7:0]          ctl;          // control bits, out bit kept apart
  logic [PER_W-1:0]    period;       // period_register
  logic [4:0]          cfg;          // run, prescale, trigger, enable
  logic                match_flag;   // channel_match_flag
  logic                per_flag;     // period_timer_flag
  logic [CMP_W-1:0]    cmp_count;    // compare_timebase_counter
  logic                out_latch;    // compare and pwm output latch
  logic                pulse_live;   // pulse mode output is high
  logic [DUTY_W-1:0]   duty_buf;     // buffered pwm duty
  logic                wrap_q;       // period wrapped last edge
  capc_cmp_state_t     state;        // compare match sequence
  capc_cmp_state_t     next_state;   // next compare state

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire [3:0]        mode     = ctl[CTL_MODE_HI:0];
  wire              en       = ctl[CTL_EN_BIT];
  wire              is_pwm   = en && (mode[3:2] == MODE_PWM_TOP);
  wire              is_cmp   = en && ((mode == MODE_TOG_CLR) || (mode == MODE_TOG)
                               || (mode[3:2] == MODE_CMP_TOP));
  wire              clr_mode = (mode == MODE_TOG_CLR) || (mode == MODE_PULSE_CLR);
  wire              pulse_md = (mode == MODE_PULSE) || (mode == MODE_PULSE_CLR);
  wire              cmp_eq   = (cmp_count == value);
  wire              cmp_event = is_cmp && cmp_eq && (state == ST_WAIT);
  wire [PER_W-1:0]  ptmr;       // period timer count
  wire [DUTY_W-1:0] base;       // pwm time base
  wire              wrap;       // period end at this edge
  wire              fmt      = ctl[CTL_FMT_BIT];
  // duty justification inside the value register
  wire [DUTY_W-1:0] duty_new = fmt ? {value[15:8], value[7:6]}
                                   : {value[9:8], value[7:0]};

  // apb decode
  wire [9:0]  idx    = PADDR_IN[ADDR_W-1:2];
  wire        hit_value  = (idx == IDX_VALUE);
  wire        hit_ctl    = (idx == IDX_CTL);
  wire        hit_period = (idx == IDX_PERIOD);
  wire        hit_cfg    = (idx == IDX_CFG);
  wire        hit_sts    = (idx == IDX_STS);
  wire        hit_ptmr   = (idx == IDX_PTMR);
  wire        hit_ctmr   = (idx == IDX_CTMR);
  wire        mapped     = hit_value || hit_ctl || hit_period || hit_cfg || hit_sts
                           || hit_ptmr || hit_ctmr;
  wire        access     = PSEL_IN && PENABLE_IN;
  wire        wr         = access && PWRITE_IN && mapped;
  wire        wr_value   = wr && hit_value;
  wire        wr_ctl     = wr && hit_ctl;
  wire        wr_sts     = wr && hit_sts;
  wire        setup      = PSEL_IN && !PENABLE_IN;
  wire [7:0]  ctl_rd     = {ctl[7:6], out_latch, ctl[4:0]};
  wire [DATA_W-1:0] rd_mux =
      hit_value  ? {{(DATA_W-CMP_W){1'b0}}, value} :
      hit_ctl    ? {24'h000000, ctl_rd} :
      hit_period ? {{(DATA_W-PER_W){1'b0}}, period} :
      hit_cfg    ? {27'h0000000, cfg} :
      hit_sts    ? {30'h00000000, per_flag, match_flag} :
      hit_ptmr   ? {{(DATA_W-PER_W){1'b0}}, ptmr} :
      hit_ctmr   ? {{(DATA_W-CMP_W){1'b0}}, cmp_count} : '0;

  // timer clear one edge after the match, skipped on a value rewrite
  wire clear_now = (state == ST_HIT) && clr_mode && !wr_value;

  // refuse widths the register layout cannot serve
  if (CMP_W != 16 || PER_W != 8) begin : g_bad_width
    $error("channel serves 16-bit compare, 8-bit period");
  end

  // ----------------------------------------------------------------------
  // period timer
  // ----------------------------------------------------------------------
  // timer stands still during sleep, instruction clock assumed
  capc_period_timer #(
    .PER_W     (PER_W)
  ) u_period_timer (
    .clk_in    (CLK_IN),
    .rst_n_in  (RST_N_IN),
    .run_in    (cfg[CFG_RUN_BIT] && !SLEEP_IN),
    .ps_sel_in (cfg[CFG_PS_LSB+1:CFG_PS_LSB]),
    .period_in (period),
    .count_out (ptmr),
    .base_out  (base),
    .wrap_out  (wrap)
  );

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign PREADY_OUT  = 1'b1;                         // zero wait states
  assign PSLVERR_OUT = access && !mapped;            // unmapped answer

  // read data captured in the setup cycle
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= '0;
    end else if (setup && !PWRITE_IN) begin
      PRDATA_OUT <= rd_mux;
    end
  end

  // software registers
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      value  <= RST_VALUE;
      ctl    <= RST_CTL;
      period <= RST_PERIOD;
      cfg    <= '0;
    end else if (wr) begin
      // duty writes accepted at any time, buffered later
      if (hit_value)  value  <= PWDATA_IN[CMP_W-1:0];
      if (hit_ctl)    ctl    <= PWDATA_IN[7:0] & ~(8'h01 << CTL_OUT_BIT) & 8'hBF;
      if (hit_period) period <= PWDATA_IN[PER_W-1:0];
      if (hit_cfg)    cfg    <= PWDATA_IN[4:0];
    end
  end

  // ----------------------------------------------------------------------
  // flags, set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      match_flag <= 1'b0;
      per_flag   <= 1'b0;
    end else begin
      if (cmp_event) begin
        match_flag <= 1'b1;
      end else if (wr_sts && PWDATA_IN[STS_MATCH_BIT]) begin
        match_flag <= 1'b0;
      end
      if (wrap) begin
        per_flag <= 1'b1;
      end else if (wr_sts && PWDATA_IN[STS_PER_BIT]) begin
        per_flag <= 1'b0;
      end
    end
  end

  // conversion start and wake, registered
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ADC_TRIGGER_OUT <= 1'b0;
      WAKE_OUT        <= 1'b0;
    end else begin
      ADC_TRIGGER_OUT <= cmp_event && cfg[CFG_ADC_BIT];
      WAKE_OUT        <= SLEEP_IN && match_flag && cfg[CFG_IE_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // compare sequence and timer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT: if (cmp_event) next_state = ST_HIT;
      ST_HIT:  next_state = ST_HOLD;
      ST_HOLD: if (!cmp_eq || !is_cmp) next_state = ST_WAIT;
      default: next_state = ST_WAIT;
    endcase
  end

  // counts only on its own ticks, so sleep compare needs a running tick
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state     <= ST_WAIT;
      cmp_count <= '0;
    end else begin
      state <= next_state;
      if (clear_now) begin
        cmp_count <= '0;
      end else if (COMPARE_TICK_IN) begin
        cmp_count <= cmp_count + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // output latch
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      out_latch  <= 1'b0;
      pulse_live <= 1'b0;
      duty_buf   <= '0;
      wrap_q     <= 1'b0;
    end else begin
      wrap_q <= wrap && is_pwm;
      if (wrap) begin
        duty_buf <= duty_new;
      end
      if ((wr_ctl && PWDATA_IN[7:0] == 8'h00) || mode == MODE_OFF || !en) begin
        out_latch  <= 1'b0;
        pulse_live <= 1'b0;
      end else if (is_pwm) begin
        pulse_live <= 1'b0;
        if (wrap_q && duty_buf != '0) begin
          out_latch <= 1'b1;
        end else if (base == duty_buf) begin
          out_latch <= 1'b0;
        end
        // duty beyond period never matches, pin stays as it is
      end else if (cmp_event) begin
        case (mode)
          MODE_TOG_CLR, MODE_TOG: out_latch <= !out_latch;
          MODE_SET:               out_latch <= 1'b1;
          MODE_CLR:               out_latch <= 1'b0;
          default: begin
            out_latch  <= 1'b1;
            pulse_live <= 1'b1;
          end
        endcase
      end else if (pulse_live && COMPARE_TICK_IN) begin
        out_latch  <= 1'b0;
        pulse_live <= 1'b0;
      end
    end
  end

  assign CHANNEL_OUTPUT_PIN_OUT = out_latch;
  assign CHANNEL_SIGNAL_OUT     = out_latch;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_flag_on_match: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    cmp_event |=> match_flag) else $error("match flag not set");
  a_adc_from_match: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ADC_TRIGGER_OUT |-> $past(cmp_event) && match_flag) else $error("stray trigger");
  a_timer_clear: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    cmp_event && clr_mode ##1 !wr_value |=> cmp_count == '0) else $error("no clear");
  a_clear_skipped: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (state == ST_HIT) && wr_value && !COMPARE_TICK_IN |=> $stable(cmp_count))
    else $error("clear not skipped");
  a_zero_ctrl: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    wr_ctl && PWDATA_IN[7:0] == 8'h00 |=> !CHANNEL_OUTPUT_PIN_OUT ##1 !CHANNEL_OUTPUT_PIN_OUT)
    else $error("latch not cleared");
  a_pwm_set: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    is_pwm && wrap && duty_new != '0 && !wr_ctl ##1 is_pwm |=> out_latch)
    else $error("pwm not set");
  a_pwm_low: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    is_pwm && !wrap_q && base == duty_buf |=> !out_latch) else $error("pwm not low");
  a_duty_hold: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !wrap |=> $stable(duty_buf)) else $error("duty changed mid period");
  a_pulse_tick: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    pulse_live && COMPARE_TICK_IN && !cmp_event |=> !out_latch) else $error("pulse long");

endmodule : capc_top
`default_nettype wire

// ==== capc_load.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// load on the channel pin: high time and period in clocks
// ----------------------------------------------------------------------
module capc_load (
  input  wire logic        clk_in,     // oscillator clock
  input  wire logic        rst_n_in,   // synchronous reset
  input  wire logic        pin_in,     // pin level seen by the load
  output logic      [15:0] high_out,   // last completed high time
  output logic      [15:0] period_out  // last rise to rise time
);
  logic        prev;                   // pin one clock ago
  logic [15:0] hc;                     // running high count
  logic [15:0] pc;                     // running period count
  // measure edges of the pin
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev       <= 1'b0;
      hc         <= 16'h0000;
      pc         <= 16'h0000;
      high_out   <= 16'h0000;
      period_out <= 16'h0000;
    end else begin
      prev <= pin_in;
      if (pin_in && !prev) begin
        period_out <= pc;
        pc         <= 16'h0001;
        hc         <= 16'h0001;
      end else begin
        pc <= pc + 16'h0001;
        if (pin_in) hc <= hc + 16'h0001;
      end
      if (!pin_in && prev) high_out <= hc;
    end
  end
endmodule : capc_load
`default_nettype wire

// ==== tb_compare_and_pwm_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_compare_and_pwm_channel;
  import capc_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, tick, sleep, pready, pslverr, pin, sig, adc, wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] hi_t, per_t, c, r;
  logic        rerr;
  int          n_mismatch, checks_done, n;
  // rows: mode, pin after match, pin after next tick, timer cleared
  localparam logic [15:0] ROWS [6] = '{16'h1111, 16'h2110, 16'h8110,
                                       16'h9000, 16'hA100, 16'hB101};
  capc_top dut (.CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COMPARE_TICK_IN(tick), .SLEEP_IN(sleep),
    .CHANNEL_OUTPUT_PIN_OUT(pin), .CHANNEL_SIGNAL_OUT(sig), .ADC_TRIGGER_OUT(adc),
    .WAKE_OUT(wake));
  capc_load load (.clk_in(clk), .rst_n_in(rst_n), .pin_in(pin), .high_out(hi_t),
    .period_out(per_t));
  // ----------------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      summarize();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask : apb
  // one compare timer step
  task automatic step;
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
  endtask : step
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; tick = 1'b0; sleep = 1'b0; n_mismatch = 0; checks_done = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, IDX_PERIOD, 32'h0); chk(rdat, 32'h0000_00FF);
    apb(1'b0, IDX_CTL, 32'h0); chk(rdat, 32'h0);
    apb(1'b0, 10'h000, 32'h0); chk({rerr, rdat[30:0]}, 32'h8000_0000);
    sleep <= 1'b1;
    apb(1'b1, IDX_CFG, 32'h18);
    apb(1'b1, IDX_VALUE, 32'hFFFF);
    // every compare mode from the table
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      apb(1'b1, IDX_CTL, 32'h0);
      @(negedge clk) chk(pin, 1'b0);
      apb(1'b1, IDX_CTL, {24'h0, 4'h8, r[15:12]});
      apb(1'b0, IDX_CTMR, 32'h0);
      c = rdat[15:0] + 16'h0001;
      apb(1'b1, IDX_VALUE, {16'h0, c});
      step();
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (adc !== 1'b1 && n < 10);
      chk(adc, 1'b1);
      if (adc !== 1'b1) summarize();
      @(negedge clk) chk(pin, r[8]);
      chk(sig, pin);
      apb(1'b0, IDX_CTMR, 32'h0); chk(rdat, r[0] ? 32'h0 : {16'h0, c});
      chk(wake, 1'b1);
      apb(1'b0, IDX_STS, 32'h0); chk(rdat[0], 1'b1);
      apb(1'b1, IDX_STS, 32'h1);
      apb(1'b1, IDX_VALUE, 32'hFFFF);
      step();
      @(negedge clk) chk(pin, r[4]);
      chk(wake, 1'b0);
    end
    // value rewrite one edge after the match keeps the timer
    apb(1'b1, IDX_CTL, 32'h81);
    apb(1'b0, IDX_CTMR, 32'h0);
    c = rdat[15:0] + 16'h0001;
    apb(1'b1, IDX_VALUE, {16'h0, c});
    fork
      step();
      begin
        @(posedge clk);
        apb(1'b1, IDX_VALUE, 32'hFFFF);
      end
    join
    apb(1'b0, IDX_CTMR, 32'h0); chk(rdat, {16'h0, c});
    // pwm set up in the documented order
    sleep <= 1'b0;
    apb(1'b1, IDX_CTL, 32'h0);
    apb(1'b1, IDX_PERIOD, 32'h3);
    apb(1'b1, IDX_CTL, 32'h8C);
    apb(1'b1, IDX_VALUE, 32'h6);
    apb(1'b1, IDX_STS, 32'h3);
    apb(1'b1, IDX_CFG, 32'h1);
    repeat (60) @(negedge clk);
    chk(hi_t, 16'd6);
    chk(per_t, 16'd16);
    apb(1'b0, IDX_STS, 32'h0); chk(rdat[1], 1'b1);
    apb(1'b1, IDX_CTL, 32'h9C);
    apb(1'b1, IDX_VALUE, 32'h0280);
    repeat (60) @(negedge clk);
    chk(hi_t, 16'd10);
    apb(1'b1, IDX_VALUE, 32'h0500);
    repeat (40) @(negedge clk);
    for (int j = 0; j < 20; j++) @(negedge clk) chk(pin, 1'b1);
    // prescale 1:4 stretches both high time and period
    apb(1'b1, IDX_VALUE, 32'h0200);
    apb(1'b1, IDX_CFG, 32'h3);
    repeat (260) @(negedge clk);
    chk(hi_t, 16'd32);
    chk(per_t, 16'd64);
    // reset in mid-run returns the channel to its reset state
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk) chk(pin, 1'b0);
    apb(1'b0, IDX_PERIOD, 32'h0); chk(rdat, 32'h0000_00FF);
    summarize();
  end
endmodule : tb_compare_and_pwm_channel
`default_nettype wire
